//--- hdl/art_timer.sv
// Chosen here: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module art_timer
    import art_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic ext_osc,
    output logic irq_req
);

    art_state_t s_q;
    art_state_t s_d;

    logic ext_edge;
    logic tick_sys12;
    logic tick_ext;

    // ------------------------------------------------------------
    // Count clock sources
    // ------------------------------------------------------------
    // Rising edges of the sampled oscillator feed the divide-by-8;
    // its wrap is the falling edge of the divided clock
    assign ext_edge = ext_osc && !s_q.ext_prev;

    art_prescale #(
        .DIV(SYS_DIV)
    ) u_div_sys (
        .aclk(aclk),
        .aresetn(aresetn),
        .step(1'b1),
        .tick(tick_sys12)
    );

    art_prescale #(
        .DIV(EXT_DIV)
    ) u_div_ext (
        .aclk(aclk),
        .aresetn(aresetn),
        .step(ext_edge),
        .tick(tick_ext)
    );

    function automatic logic pick_tick(input logic sys_sel, input logic ext_sel,
                                       input logic t12, input logic text);
        if (sys_sel)
        begin
            return 1'b1;
        end
        return ext_sel ? text : t12;
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        logic tick_lo;
        logic tick_hi;
        logic set_hf;
        logic set_lf;
        logic capture;
        logic do_write;
        logic hit;
        logic [15:0] cnt16;
        logic [7:0] rbyte;

        s_d = s_q;
        tick_lo = 1'b0;
        tick_hi = 1'b0;
        set_hf = 1'b0;
        set_lf = 1'b0;
        capture = 1'b0;
        do_write = 1'b0;
        hit = 1'b0;
        cnt16 = {s_q.count_high_byte, s_q.count_low_byte};
        rbyte = 8'h00;

        s_d.ext_prev = ext_osc;

        // Clock choice per half; capture replaces the external source of the low half only with /12
        if (s_q.ctrl.capture_enable)
        begin
            tick_lo = pick_tick(s_q.low_half_clock_select, 1'b0, tick_sys12, tick_ext);
        end
        else
        begin
            tick_lo = pick_tick(s_q.low_half_clock_select, s_q.ctrl.ext_clock_select,
                                tick_sys12, tick_ext);
        end
        tick_hi = pick_tick(s_q.high_half_clock_select, s_q.ctrl.ext_clock_select,
                            tick_sys12, tick_ext);

        // --------------------------------------------------------
        // Counting
        // --------------------------------------------------------
        if (!s_q.ctrl.split_mode_select)
        begin
            if (s_q.ctrl.run_control && tick_lo)
            begin
                if (s_q.count_low_byte == 8'hff)
                begin
                    set_lf = 1'b1;
                end
                if (cnt16 == 16'hffff)
                begin
                    s_d.count_low_byte = s_q.reload_low_byte;
                    s_d.count_high_byte = s_q.reload_high_byte;
                    set_hf = 1'b1;
                end
                else
                begin
                    cnt16 = cnt16 + 16'h0001;
                    s_d.count_low_byte = cnt16[7:0];
                    s_d.count_high_byte = cnt16[15:8];
                end
            end
        end
        else
        begin
            if (tick_lo)
            begin
                if (s_q.count_low_byte == 8'hff)
                begin
                    s_d.count_low_byte = s_q.reload_low_byte;
                    set_lf = 1'b1;
                end
                else
                begin
                    s_d.count_low_byte = s_q.count_low_byte + 8'h01;
                end
            end
            if (s_q.ctrl.run_control && tick_hi)
            begin
                if (s_q.count_high_byte == 8'hff)
                begin
                    s_d.count_high_byte = s_q.reload_high_byte;
                    set_hf = 1'b1;
                end
                else
                begin
                    s_d.count_high_byte = s_q.count_high_byte + 8'h01;
                end
            end
        end

        // --------------------------------------------------------
        // Capture of the count on each falling edge of external /8
        // --------------------------------------------------------
        capture = s_q.ctrl.capture_enable && tick_ext;

        // --------------------------------------------------------
        // AXI4-Lite write channel
        // --------------------------------------------------------
        if (s_axi_awvalid && s_q.awready)
        begin
            s_d.awready = 1'b0;
            s_d.waddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_q.wready)
        begin
            s_d.wready = 1'b0;
            s_d.wbyte = s_axi_wdata[7:0];
            s_d.wlane = s_axi_wstrb[0];
        end
        if (!s_q.awready && !s_q.wready && !s_q.bvalid)
        begin
            do_write = s_q.wlane;
            hit = 1'b1;
            unique case (s_q.waddr)
                OFS_CTRL:
                begin
                    if (do_write)
                    begin
                        s_d.ctrl.high_overflow_flag = s_q.wbyte[BIT_HIGH_FLAG];
                        s_d.ctrl.low_overflow_flag = s_q.wbyte[BIT_LOW_FLAG];
                        s_d.ctrl.low_byte_irq_enable = s_q.wbyte[BIT_LOW_IRQ_EN];
                        s_d.ctrl.capture_enable = s_q.wbyte[BIT_CAPTURE_EN];
                        s_d.ctrl.split_mode_select = s_q.wbyte[BIT_SPLIT];
                        s_d.ctrl.run_control = s_q.wbyte[BIT_RUN];
                        s_d.ctrl.ext_clock_select = s_q.wbyte[BIT_EXT_CLK];
                    end
                end
                OFS_CLK_SEL:
                begin
                    if (do_write)
                    begin
                        s_d.high_half_clock_select = s_q.wbyte[BIT_HIGH_CLK_SEL];
                        s_d.low_half_clock_select = s_q.wbyte[BIT_LOW_CLK_SEL];
                    end
                end
                OFS_RELOAD_LO:
                begin
                    if (do_write)
                    begin
                        s_d.reload_low_byte = s_q.wbyte;
                    end
                end
                OFS_RELOAD_HI:
                begin
                    if (do_write)
                    begin
                        s_d.reload_high_byte = s_q.wbyte;
                    end
                end
                OFS_COUNT_LO:
                begin
                    if (do_write)
                    begin
                        s_d.count_low_byte = s_q.wbyte;
                    end
                end
                OFS_COUNT_HI:
                begin
                    if (do_write)
                    begin
                        s_d.count_high_byte = s_q.wbyte;
                    end
                end
                OFS_IRQ_EN:
                begin
                    if (do_write)
                    begin
                        s_d.timer_irq_enable = s_q.wbyte[BIT_TIMER_IRQ_EN];
                    end
                end
                default:
                begin
                    hit = 1'b0;
                end
            endcase
            s_d.bvalid = 1'b1;
            s_d.bresp = hit ? RESP_OKAY : RESP_SLVERR;
        end
        if (s_q.bvalid && s_axi_bready)
        begin
            s_d.bvalid = 1'b0;
            s_d.awready = 1'b1;
            s_d.wready = 1'b1;
        end

        // Capture wins over a software write of the reload bytes
        if (capture)
        begin
            s_d.reload_low_byte = s_q.count_low_byte;
            s_d.reload_high_byte = s_q.count_high_byte;
            set_hf = 1'b1;
        end

        // Hardware set wins over a software clear in the same cycle
        s_d.ctrl.high_overflow_flag = s_d.ctrl.high_overflow_flag | set_hf;
        s_d.ctrl.low_overflow_flag = s_d.ctrl.low_overflow_flag | set_lf;

        // --------------------------------------------------------
        // AXI4-Lite read channel
        // --------------------------------------------------------
        if (s_axi_arvalid && s_q.arready)
        begin
            hit = 1'b1;
            unique case (s_axi_araddr)
                OFS_CTRL:
                begin
                    rbyte = {s_q.ctrl.high_overflow_flag, s_q.ctrl.low_overflow_flag,
                             s_q.ctrl.low_byte_irq_enable, s_q.ctrl.capture_enable,
                             s_q.ctrl.split_mode_select, s_q.ctrl.run_control,
                             1'b0, s_q.ctrl.ext_clock_select};
                end
                OFS_CLK_SEL:
                begin
                    rbyte = {s_q.high_half_clock_select, s_q.low_half_clock_select, 6'h00};
                end
                OFS_RELOAD_LO:
                begin
                    rbyte = s_q.reload_low_byte;
                end
                OFS_RELOAD_HI:
                begin
                    rbyte = s_q.reload_high_byte;
                end
                OFS_COUNT_LO:
                begin
                    rbyte = s_q.count_low_byte;
                end
                OFS_COUNT_HI:
                begin
                    rbyte = s_q.count_high_byte;
                end
                OFS_IRQ_EN:
                begin
                    rbyte = {7'h00, s_q.timer_irq_enable};
                end
                default:
                begin
                    hit = 1'b0;
                end
            endcase
            s_d.arready = 1'b0;
            s_d.rvalid = 1'b1;
            s_d.rdata = {24'h000000, rbyte};
            s_d.rresp = hit ? RESP_OKAY : RESP_SLVERR;
        end
        if (s_q.rvalid && s_axi_rready)
        begin
            s_d.rvalid = 1'b0;
            s_d.arready = 1'b1;
        end

        // --------------------------------------------------------
        // Interrupt request from the sticky flags
        // --------------------------------------------------------
        s_d.irq = s_q.timer_irq_enable
                  && (s_q.ctrl.high_overflow_flag
                      || (s_q.ctrl.low_byte_irq_enable && s_q.ctrl.low_overflow_flag));
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_q <= '0;
            s_q.reload_low_byte <= RESET_BYTE;
            s_q.reload_high_byte <= RESET_BYTE;
            s_q.count_low_byte <= RESET_BYTE;
            s_q.count_high_byte <= RESET_BYTE;
            s_q.awready <= 1'b1;
            s_q.wready <= 1'b1;
            s_q.arready <= 1'b1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign s_axi_awready = s_q.awready;
    assign s_axi_wready = s_q.wready;
    assign s_axi_bvalid = s_q.bvalid;
    assign s_axi_bresp = s_q.bresp;
    assign s_axi_arready = s_q.arready;
    assign s_axi_rvalid = s_q.rvalid;
    assign s_axi_rdata = s_q.rdata;
    assign s_axi_rresp = s_q.rresp;
    assign irq_req = s_q.irq;

endmodule

//--- common/art_pkg.sv
package art_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CLK_SEL = 8'h04;
    localparam logic [7:0] OFS_RELOAD_LO = 8'h08;
    localparam logic [7:0] OFS_RELOAD_HI = 8'h0c;
    localparam logic [7:0] OFS_COUNT_LO = 8'h10;
    localparam logic [7:0] OFS_COUNT_HI = 8'h14;
    localparam logic [7:0] OFS_IRQ_EN = 8'h18;

    // Bit positions in the control register
    localparam int unsigned BIT_HIGH_FLAG = 7;
    localparam int unsigned BIT_LOW_FLAG = 6;
    localparam int unsigned BIT_LOW_IRQ_EN = 5;
    localparam int unsigned BIT_CAPTURE_EN = 4;
    localparam int unsigned BIT_SPLIT = 3;
    localparam int unsigned BIT_RUN = 2;
    localparam int unsigned BIT_EXT_CLK = 0;
    // Bit positions in the clock select and interrupt enable registers
    localparam int unsigned BIT_HIGH_CLK_SEL = 7;
    localparam int unsigned BIT_LOW_CLK_SEL = 6;
    localparam int unsigned BIT_TIMER_IRQ_EN = 0;

    localparam logic [7:0] RESET_BYTE = 8'h00;

    // ------------------------------------------------------------
    // Clock dividers
    // ------------------------------------------------------------
    localparam logic [3:0] SYS_DIV = 4'hc;
    localparam logic [3:0] EXT_DIV = 4'h8;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic high_overflow_flag;
        logic low_overflow_flag;
        logic low_byte_irq_enable;
        logic capture_enable;
        logic split_mode_select;
        logic run_control;
        logic ext_clock_select;
    } art_ctrl_t;

    typedef struct packed {
        art_ctrl_t ctrl;
        logic high_half_clock_select;
        logic low_half_clock_select;
        logic timer_irq_enable;
        logic [7:0] reload_low_byte;
        logic [7:0] reload_high_byte;
        logic [7:0] count_low_byte;
        logic [7:0] count_high_byte;
        logic ext_prev;
        logic awready;
        logic wready;
        logic [7:0] waddr;
        logic [7:0] wbyte;
        logic wlane;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic irq;
    } art_state_t;

    typedef struct packed {
        logic [3:0] cnt;
    } art_pre_state_t;

endpackage

//--- hdl/art_prescale.sv
`timescale 1ns/1ps
module art_prescale
    import art_pkg::*;
#(
    parameter logic [3:0] DIV = 4'h8
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic step,
    output logic tick
);

    art_pre_state_t s_q;
    art_pre_state_t s_d;

    // Tick marks the last step of each group of DIV steps
    always_comb
    begin
        s_d = s_q;
        tick = step && (s_q.cnt == DIV - 4'h1);
        if (step)
        begin
            s_d.cnt = tick ? 4'h0 : s_q.cnt + 4'h1;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

endmodule

//--- bench/art_timer_props.sv
`timescale 1ns/1ps
module art_timer_props
    import art_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic irq_req
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // ------------------------------------------------------------
    // Register bus handshakes, read data width and interrupt release
    // ------------------------------------------------------------
    aw_taken_low_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
        else $error("awready stayed high after address taken");
    write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid)
        else $error("write response not two edges after handshake");
    write_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write channels ready while response pending");
    write_release_a: assert property (s_axi_bvalid && s_axi_bready
        |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
        else $error("write channels not released after response");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read data not one edge after address");
    read_release_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
        else $error("read channel not released after data");
    rdata_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
    irq_clear_a: assert property ($fell(irq_req) |-> s_axi_bvalid || $past(s_axi_bvalid))
        else $error("interrupt dropped without a software write");
endmodule

bind art_timer art_timer_props u_props (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .irq_req(irq_req));

//--- bench/auto_reload_timer_with_capture_tb_top.sv
`timescale 1ns/1ps
module auto_reload_timer_with_capture_tb_top
    import art_pkg::*;
;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h00000000;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic ext_osc = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp, r;
    logic [31:0] rdata, d, d2;
    int error_cnt = 0;
    int checked = 0;
    int ctl, csel, ien, rl, rh, cl, ch, edges;
    bit [31:0] seed = 32'h000037b3;

    initial forever #2 aclk = ~aclk;

    art_timer DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ext_osc(ext_osc), .irq_req(irq));

    // ------------------------------------------------------------
    // Reporting
    // ------------------------------------------------------------
    task final_report();
        $display("Checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task hang(input int i);
        if (i > 50)
        begin
            error_cnt++;
            $display("Error bus wait expected answer seen none");
            final_report();
        end
    endtask

    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction

    // ------------------------------------------------------------
    // Bus master
    // ------------------------------------------------------------
    task wr(input logic [7:0] a, input logic [7:0] v, input logic [3:0] st);
        bit aw, w;
        int i;
        aw = 0;
        w = 0;
        i = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h000000, v};
        wstrb <= st;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            aw = aw | awready;
            w = w | wready;
            i++;
            hang(i);
        end while (!(aw && w));
        bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            i++;
            hang(i);
        end while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask

    task rd(input logic [7:0] a, output logic [31:0] v);
        int i;
        i = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            i++;
            hang(i);
        end while (rvalid !== 1'b1);
        v = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    // ------------------------------------------------------------
    // Reference model
    // ------------------------------------------------------------
    function automatic logic [1:0] exp_resp(input logic [7:0] a);
        return (a <= OFS_IRQ_EN && a[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
    endfunction

    function automatic logic [31:0] exp_rd(input logic [7:0] a);
        case (a)
            OFS_CTRL: return 32'(ctl & 'hfd);
            OFS_CLK_SEL: return 32'(csel & 'hc0);
            OFS_RELOAD_LO: return 32'(rl);
            OFS_RELOAD_HI: return 32'(rh);
            OFS_COUNT_LO: return 32'(cl);
            OFS_COUNT_HI: return 32'(ch);
            OFS_IRQ_EN: return 32'(ien & 1);
            default: return 32'h00000000;
        endcase
    endfunction

    task mw(input logic [7:0] a, input logic [7:0] v);
        wr(a, v, 4'h1);
        check("bresp", 32'(exp_resp(a)), 32'(r));
        case (a)
            OFS_CTRL: ctl = v;
            OFS_CLK_SEL: csel = v;
            OFS_RELOAD_LO: rl = v;
            OFS_RELOAD_HI: rh = v;
            OFS_COUNT_LO: cl = v;
            OFS_COUNT_HI: ch = v;
            OFS_IRQ_EN: ien = v;
            default: ;
        endcase
    endtask

    task rc(input logic [7:0] a);
        rd(a, d);
        check("rdata", exp_rd(a), d);
        check("rresp", 32'(exp_resp(a)), 32'(r));
    endtask

    task sync();
        for (int a = 0; a <= 'h14; a += 4) rc(8'(a));
        check("irq_req", 32'(ien & (ctl[7] | (ctl[5] & ctl[6]))), {31'h0, irq});
    endtask

    task m_tick();
        bit lo, hi;
        lo = !csel[6] && ctl[0];
        hi = !csel[7] && ctl[0];
        if (ctl[4])
        begin
            rl = cl;
            rh = ch;
            ctl[7] = 1'b1;
        end
        else if (ctl[3])
        begin
            cl += lo;
            ch += hi && ctl[2];
            if (cl == 256) {cl, ctl[6]} = {rl, 1'b1};
            if (ch == 256) {ch, ctl[7]} = {rh, 1'b1};
        end
        else if (lo && ctl[2])
        begin
            cl++;
            if (cl == 256)
            begin
                {cl, ctl[6]} = {32'h0, 1'b1};
                ch++;
                if (ch == 256) {cl, ch, ctl[7]} = {rl, rh, 1'b1};
            end
        end
    endtask

    task pulse(input int n);
        repeat (n)
        begin
            @(posedge aclk);
            ext_osc <= 1'b1;
            @(posedge aclk);
            ext_osc <= 1'b0;
            edges++;
            if (edges % 8 == 0) m_tick();
        end
        repeat (3) @(posedge aclk);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        {ctl, csel, ien, rl, rh, cl, ch, edges} = '0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        for (int a = 0; a <= 'h1c; a += 4) rc(8'(a));
        mw(8'h1c, 8'hff);
        wr(OFS_RELOAD_LO, 8'h5a, 4'h0);
        check("bresp", 32'(RESP_OKAY), 32'(r));
        rc(OFS_RELOAD_LO);
        mw(OFS_IRQ_EN, 8'h01);
        mw(OFS_RELOAD_LO, rnd());
        mw(OFS_RELOAD_HI, rnd());
        mw(OFS_COUNT_LO, 8'hf8);
        mw(OFS_COUNT_HI, 8'hff);
        mw(OFS_CTRL, 8'h05);
        pulse(8 * (8 + rnd() % 8));
        sync();
        mw(OFS_CTRL, 8'h25);
        mw(OFS_COUNT_LO, 8'hfe);
        mw(OFS_COUNT_HI, 8'h00);
        pulse(24);
        sync();
        mw(OFS_CTRL, 8'h45);
        sync();
        mw(OFS_CTRL, 8'h09);
        mw(OFS_COUNT_LO, 8'hfc);
        mw(OFS_COUNT_HI, 8'hfe);
        pulse(48);
        sync();
        mw(OFS_CTRL, 8'h2d);
        pulse(32);
        sync();
        mw(OFS_CTRL, 8'h09);
        mw(OFS_CLK_SEL, 8'h80);
        pulse(24);
        sync();
        mw(OFS_COUNT_LO, 8'h00);
        mw(OFS_COUNT_HI, 8'h00);
        mw(OFS_CLK_SEL, 8'h40);
        mw(OFS_CTRL, 8'h04);
        rd(OFS_COUNT_LO, d);
        rd(OFS_COUNT_LO, d2);
        check("count moves", 32'h3, d2 - d);
        mw(OFS_CTRL, 8'h00);
        mw(OFS_CLK_SEL, 8'h00);
        // Divide-by-12 source: 120 running cycles give 10 counts
        mw(OFS_COUNT_LO, 8'h00);
        mw(OFS_COUNT_HI, 8'h00);
        mw(OFS_CTRL, 8'h04);
        repeat (116) @(posedge aclk);
        mw(OFS_CTRL, 8'h00);
        cl = 120 / SYS_DIV;
        sync();
        mw(OFS_CTRL, 8'h10);
        mw(OFS_COUNT_LO, rnd());
        mw(OFS_COUNT_HI, rnd());
        pulse(8);
        sync();
        mw(OFS_CTRL, 8'h00);
        pulse(8);
        sync();
        final_report();
    end
endmodule
